// >>> cpu_step_core.sv
// APB-reachable execution block for decrement, increment and halt instructions
`timescale 1ns/10ps
`default_nettype none
module cpu_step_core
  import cpu_step_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   sys_clk_en,
  output logic                   halted
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  core_s             st_r;          // Registered state
  core_s             st_nxt;        // Next state
  logic [7:0]        operand;       // Addressed memory byte
  logic [7:0]        alu_res;       // Inc/dec result
  logic              alu_zero;      // Result is zero
  logic              req_first;     // First access cycle
  logic              commit;        // Write completes this edge
  logic              is_mem;        // Address in memory window
  logic [3:0]        mem_idx;       // Word index in window
  logic              idle;          // No instruction in flight
  logic              hit;           // Address decodes
  logic              wr_refused;    // Write not allowed now
  logic [DATA_W-1:0] rd_val;        // Read mux output
  logic              wdt_pre_wrap;  // Prescaler at its top

  assign operand = st_r.mem[st_r.addr];
  assign idle    = (st_r.state == S_IDLE);

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  cpu_step_alu u_alu (
    .op      (st_r.op),
    .operand (operand),
    .result  (alu_res),
    .zero    (alu_zero)
  );

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  // Word aligned only; byte lanes other than zero are unmapped
  always_comb begin
    is_mem  = (paddr[7:6] == MEM_PAGE) && (paddr[1:0] == 2'h0);
    mem_idx = paddr[5:2];
    rd_val  = '0;
    hit     = 1'b1;
    if (is_mem) begin
      rd_val = {24'h000000, st_r.mem[mem_idx]};
    end else begin
      case (paddr)
        OFS_INSTR:  rd_val = {22'h000000, st_r.op, 4'h0, st_r.addr};
        OFS_WREG:   rd_val = {24'h000000, st_r.working_register};
        OFS_STATUS: begin
          rd_val[ST_ZERO_BIT] = st_r.zero;
          rd_val[ST_PWRDN_BIT]  = st_r.power_down_flag;
          rd_val[ST_EXPIRY_BIT] = st_r.watchdog_expiry_flag;
          rd_val[ST_BUSY_BIT] = !idle && (st_r.state != S_HALT);
          rd_val[ST_HALT_BIT] = (st_r.state == S_HALT);
        end
        OFS_WDOG:   rd_val = {16'h0000, st_r.watchdog_counter, st_r.wdt_pre};
        OFS_WAKE:   rd_val = '0;           // Write-only strobe
        default:    hit    = 1'b0;         // Unmapped
      endcase
    end
  end

  // Writes that would disturb a running or halted core are refused
  always_comb begin
    wr_refused = 1'b0;
    if (pwrite && (is_mem || paddr == OFS_INSTR || paddr == OFS_WREG)) begin
      wr_refused = !idle;
    end
  end

  assign req_first    = psel && penable && !st_r.pready;
  assign commit       = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
  assign wdt_pre_wrap = (st_r.wdt_pre == WDOG_MAX);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;

    // APB: one wait cycle, answer registered
    if (req_first) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !hit || wr_refused;
      st_nxt.prdata  = pwrite ? '0 : (hit ? rd_val : '0);
    end

    // Watchdog runs only while the system clock runs
    if (st_r.state != S_HALT) begin
      st_nxt.wdt_pre = st_r.wdt_pre + ONE;
      if (wdt_pre_wrap) begin
        st_nxt.watchdog_counter = st_r.watchdog_counter + ONE;
        if (st_r.watchdog_counter == WDOG_MAX) begin
          st_nxt.watchdog_expiry_flag = 1'b1;
        end
      end
    end

    // Software writes, taken at the completing edge
    if (commit) begin
      if (is_mem) begin
        st_nxt.mem[mem_idx] = pwdata[7:0];
      end else if (paddr == OFS_WREG) begin
        st_nxt.working_register = pwdata[7:0];
      end else if (paddr == OFS_INSTR) begin
        st_nxt.op    = op_e'(pwdata[INSTR_OP_LSB +: 2]);
        st_nxt.addr  = pwdata[INSTR_ADDR_LSB +: 4];
        st_nxt.state = S_FETCH;
      end else if (paddr == OFS_WAKE && st_r.state == S_HALT) begin
        // Flags stay as halt left them for software to inspect
        st_nxt.state      = S_IDLE;
        st_nxt.sys_clk_en = 1'b1;
        st_nxt.halted     = 1'b0;
      end
    end

    // Sequencer
    case (st_r.state)
      S_IDLE: begin
        // Held here until an instruction write commits
      end
      S_FETCH: begin
        st_nxt.state = S_EXEC;
      end
      S_EXEC: begin
        st_nxt.state = S_IDLE;
        case (st_r.op)
          OP_DEC_TO_W: begin
            st_nxt.working_register = alu_res;
            st_nxt.zero             = alu_zero;
          end
          OP_INC_MEM: begin
            st_nxt.mem[st_r.addr] = alu_res;
            st_nxt.zero           = alu_zero;
          end
          OP_INC_TO_W: begin
            st_nxt.working_register = alu_res;
            st_nxt.zero             = alu_zero;
          end
          OP_HALT: begin
            // Instruction semantics win over a coincident watchdog tick
            st_nxt.state                = S_HALT;
            st_nxt.sys_clk_en           = 1'b0;
            st_nxt.halted               = 1'b1;
            st_nxt.wdt_pre              = WDOG_RST;
            st_nxt.watchdog_counter     = WDOG_RST;
            st_nxt.power_down_flag      = 1'b1;
            st_nxt.watchdog_expiry_flag = 1'b0;
          end
          default: begin
            st_nxt.state = S_IDLE;
          end
        endcase
      end
      S_HALT: begin
        // Nothing executes; memory and registers hold
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r.state                <= S_IDLE;
      st_r.op                   <= OP_DEC_TO_W;
      st_r.addr                 <= 4'h0;
      st_r.working_register     <= WREG_RST;
      st_r.zero                 <= 1'b0;
      st_r.power_down_flag      <= 1'b0;
      st_r.watchdog_expiry_flag <= 1'b0;
      st_r.wdt_pre              <= WDOG_RST;
      st_r.watchdog_counter     <= WDOG_RST;
      st_r.mem                  <= {MEM_DEPTH{MEM_RST}};
      st_r.pready               <= 1'b0;
      st_r.pslverr              <= 1'b0;
      st_r.prdata               <= '0;
      st_r.sys_clk_en           <= 1'b1;
      st_r.halted               <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign prdata     = st_r.prdata;
  assign pready     = st_r.pready;
  assign pslverr    = st_r.pslverr;
  assign sys_clk_en = st_r.sys_clk_en;
  assign halted     = st_r.halted;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Execute cycle of each opcode
  sequence exec_dec;  (st_r.state == S_EXEC) && (st_r.op == OP_DEC_TO_W); endsequence
  sequence exec_halt; (st_r.state == S_EXEC) && (st_r.op == OP_HALT);     endsequence
  sequence exec_inc;  (st_r.state == S_EXEC) && (st_r.op == OP_INC_MEM);  endsequence
  sequence exec_inca; (st_r.state == S_EXEC) && (st_r.op == OP_INC_TO_W); endsequence
  // Any single halted cycle with no committed write
  sequence halted_quiet; (st_r.state == S_HALT) && !commit; endsequence

  a_dec_result: assert property (
    exec_dec |=> (st_r.working_register == $past(operand) - ONE)
                 && (st_r.zero == ($past(operand) == ONE)))
    else $error("decrement result or zero flag wrong");

  a_dec_mem_kept: assert property (
    exec_dec |=> $stable(st_r.mem))
    else $error("decrement altered memory");

  a_halt_stops: assert property (
    exec_halt |=> (halted && !sys_clk_en) ##1 (halted && !sys_clk_en))
    else $error("halt did not stop execution and clock");

  a_halt_retains: assert property (
    halted_quiet |=> $stable(st_r.mem) && $stable(st_r.working_register)
                     && $stable(st_r.zero) && $stable(st_r.power_down_flag))
    else $error("state changed while halted");

  a_halt_wdt_clear: assert property (
    exec_halt |=> (st_r.watchdog_counter == WDOG_RST) && (st_r.wdt_pre == WDOG_RST))
    else $error("halt did not clear watchdog");

  a_halt_flags: assert property (
    exec_halt |=> st_r.power_down_flag && !st_r.watchdog_expiry_flag
                  && $stable(st_r.zero) && $stable(st_r.working_register))
    else $error("halt flags wrong");

  a_inc_mem_write: assert property (
    exec_inc |=> (st_r.mem[$past(st_r.addr)] == $past(operand) + ONE)
                 && (st_r.zero == ($past(operand) == WDOG_MAX)))
    else $error("in-place increment wrong");

  a_inca_result: assert property (
    exec_inca |=> st_r.working_register == $past(operand) + ONE)
    else $error("increment to working register wrong");

  a_inca_side: assert property (
    exec_inca |=> $stable(st_r.mem) && (st_r.zero == ($past(operand) == WDOG_MAX)))
    else $error("increment to working register side effects wrong");

  // Registered halt output tracks the sequencer state
  a_halt_out_match: assert property (
    halted == (st_r.state == S_HALT))
    else $error("halted output disagrees with state");

  // One wait state: answer follows the first access cycle
  a_apb_one_wait: assert property (
    req_first |=> pready)
    else $error("ready not raised after access cycle");

  // Ready is a single-cycle pulse
  a_apb_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  // A committed wake restarts the clock at once
  a_wake_resumes: assert property (
    (halted && commit && (paddr == OFS_WAKE)) |=> (!halted && sys_clk_en))
    else $error("wake did not restart the clock");

endmodule
`default_nettype wire

// >>> cpu_step_pkg.sv
// Shared constants, types and state layout for the inc/dec/halt execution block
// Behaviour
// - Decrement: working register gets mem minus one
// - Halt stops execution and gates system clock
// - Halt keeps data memory and registers intact
// - Halt clears watchdog counter and prescaler
// - Halt sets power-down, clears expiry flag only
// - Increment memory in place, update zero flag
// - Increment into working register from memory
package cpu_step_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 8;             // APB byte address width
  localparam int DATA_W    = 32;            // APB data width
  localparam int MEM_DEPTH = 16;            // Data memory bytes

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR  = 8'h00; // Instruction issue
  localparam logic [7:0] OFS_WREG   = 8'h04; // Working register
  localparam logic [7:0] OFS_STATUS = 8'h08; // Flags and state
  localparam logic [7:0] OFS_WDOG   = 8'h0C; // Watchdog view
  localparam logic [7:0] OFS_WAKE   = 8'h10; // Leave power-down
  localparam logic [1:0] MEM_PAGE   = 2'h1;  // paddr[7:6] of memory window (0x40..0x7C)

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INSTR_ADDR_LSB = 0;        // Operand address, 4 bits
  localparam int INSTR_OP_LSB   = 8;        // Opcode, 2 bits
  localparam int ST_ZERO_BIT    = 0;        // Result-null flag
  localparam int ST_PWRDN_BIT   = 1;        // Power-down flag
  localparam int ST_EXPIRY_BIT  = 2;        // Watchdog expiry flag
  localparam int ST_BUSY_BIT    = 3;        // Instruction in flight
  localparam int ST_HALT_BIT    = 4;        // Core halted
  localparam int WDOG_PRE_LSB   = 0;        // Prescaler byte
  localparam int WDOG_CNT_LSB   = 8;        // Counter byte

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WREG_RST = 8'h00;  // Working register
  localparam logic [7:0] MEM_RST  = 8'h00;  // Each memory byte
  localparam logic [7:0] WDOG_RST = 8'h00;  // Counter and prescaler
  localparam logic [7:0] WDOG_MAX = 8'hFF;  // Wrap point of both stages
  localparam logic [7:0] ONE     = 8'h01;   // Step of inc and dec

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_DEC_TO_W  = 2'h0,                    // decrement_to_working_register_op
    OP_HALT      = 2'h1,                    // Enter power-down
    OP_INC_MEM   = 2'h2,                    // Increment in place
    OP_INC_TO_W  = 2'h3                     // Increment to working register
  } op_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'h0,                         // Waiting for an instruction
    S_FETCH = 2'h1,                         // Operand read
    S_EXEC  = 2'h3,                         // Result written
    S_HALT  = 2'h2                          // Clock gated off
  } state_e;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    state_e                 state;          // Sequencer
    op_e                    op;             // Latched opcode
    logic [3:0]             addr;           // Latched operand address
    logic [7:0]             working_register;
    logic                   zero;           // Result-null flag
    logic                   power_down_flag;
    logic                   watchdog_expiry_flag;
    logic [7:0]             wdt_pre;        // Watchdog prescaler
    logic [7:0]             watchdog_counter;
    logic [MEM_DEPTH-1:0][7:0] mem;         // Data memory
    logic                   pready;         // APB answer
    logic                   pslverr;        // APB error answer
    logic [DATA_W-1:0]      prdata;         // APB read data
    logic                   sys_clk_en;     // System clock gate
    logic                   halted;         // Power-down state, registered
  } core_s;

endpackage

// >>> cpu_step_alu.sv
// Increment / decrement datapath with result-null detection
`timescale 1ns/10ps
`default_nettype none
module cpu_step_alu
  import cpu_step_pkg::*;
(
  input  wire op_e        op,
  input  wire logic [7:0] operand,
  output logic [7:0]      result,
  output logic            zero
);

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // Wraps modulo 256, no carry is kept
  always_comb begin
    case (op)
      OP_DEC_TO_W: result = operand - ONE;
      OP_INC_MEM:  result = operand + ONE;
      OP_INC_TO_W: result = operand + ONE;
      default:     result = operand;         // Halt computes nothing
    endcase
    zero = (result == 8'h00);
  end

endmodule
`default_nettype wire

// >>> test_cpu_inc_dec_halt_ops.sv
// Self-checking bench for the inc/dec/halt execution block over APB
`timescale 1ns/10ps
`default_nettype none
module test_cpu_inc_dec_halt_ops
  import cpu_step_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk;        // 50 MHz system clock
  logic              reset;      // Async, active high
  logic              psel;       // APB select
  logic              penable;    // APB enable
  logic              pwrite;     // APB direction
  logic [ADDR_W-1:0] paddr;      // APB byte address
  logic [DATA_W-1:0] pwdata;     // APB write data
  logic [DATA_W-1:0] prdata;     // APB read data
  logic              pready;     // APB ready
  logic              pslverr;    // APB error
  logic              sys_clk_en; // Clock gate
  logic              halted;     // Power-down state
  logic [31:0]       q;          // Last read word
  logic              e;          // Last error answer
  logic              held;       // Select kept for a chained transfer
  int                fails;      // Mismatch count
  int                checks;     // Comparison count

  cpu_step_core u_cpu_step_core (
    .clk        (clk),
    .reset      (reset),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .sys_clk_en (sys_clk_en),
    .halted     (halted)
  );

  // ----------------------------------------------------------------
  // Clock and reset
  // ----------------------------------------------------------------
  // Free-running clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single verdict point, also used by the watchdog
  task automatic wrap_up();
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer; chain keeps psel up so a setup follows at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic chain);
    int n;
    if (!held) @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Slave latency is its own; the wait ends on pready or after 50 cycles
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = prdata;
    e = pslverr;
    penable <= 1'b0;
    if (!chain) psel <= 1'b0;
    held = chain;
  endtask

  // Write and check the error answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d, 1'b0);
    check({31'h0, e}, {31'h0, xe});
  endtask

  // Read and check the word
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0);
    check(q, x);
  endtask

  // Instruction word: opcode at [9:8], operand at [3:0]
  function automatic logic [31:0] ins(input op_e op, input logic [3:0] m);
    return {22'h0, op, 4'h0, m};
  endfunction

  // Byte address of a memory cell
  function automatic logic [7:0] ma(input logic [3:0] i);
    return {MEM_PAGE, i, 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, held} = 4'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    fails  = 0;
    checks = 0;
    reset  = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_WREG, 32'h0);
    // Decrement into working register, memory untouched
    wr(ma(4'h3), 32'h01, 1'b0);
    wr(OFS_INSTR, ins(OP_DEC_TO_W, 4'h3), 1'b0);
    rd(OFS_WREG, 32'h00);
    rd(ma(4'h3), 32'h01);
    rd(OFS_STATUS, 32'h01);
    // Wrap below zero clears the zero flag
    wr(ma(4'h0), 32'h00, 1'b0);
    wr(OFS_INSTR, ins(OP_DEC_TO_W, 4'h0), 1'b0);
    rd(OFS_WREG, 32'hFF);
    rd(OFS_STATUS, 32'h00);
    // In-place increment across the wrap and back
    wr(ma(4'h5), 32'hFF, 1'b0);
    wr(OFS_INSTR, ins(OP_INC_MEM, 4'h5), 1'b0);
    rd(ma(4'h5), 32'h00);
    rd(OFS_STATUS, 32'h01);
    wr(OFS_INSTR, ins(OP_INC_MEM, 4'h5), 1'b0);
    rd(ma(4'h5), 32'h01);
    rd(OFS_STATUS, 32'h00);
    // Increment into working register
    wr(ma(4'h7), 32'h41, 1'b0);
    wr(OFS_INSTR, ins(OP_INC_TO_W, 4'h7), 1'b0);
    rd(OFS_WREG, 32'h42);
    rd(ma(4'h7), 32'h41);
    wr(ma(4'h8), 32'hFF, 1'b0);
    wr(OFS_INSTR, ins(OP_INC_TO_W, 4'h8), 1'b0);
    rd(OFS_WREG, 32'h00);
    rd(OFS_STATUS, 32'h01);
    // Second instruction while the first is in flight is refused
    wr(ma(4'h9), 32'h10, 1'b0);
    apb(1'b1, OFS_INSTR, ins(OP_INC_MEM, 4'h9), 1'b1);
    wr(OFS_INSTR, ins(OP_INC_MEM, 4'h9), 1'b1);
    rd(ma(4'h9), 32'h11);
    // Unmapped and misaligned places answer with an error
    wr(8'h20, 32'h0, 1'b1);
    apb(1'b0, 8'h41, 32'h0, 1'b0);
    check({31'h0, e}, 32'h1);
    // Let the watchdog expire so the halt has a flag to clear
    repeat (66000) @(posedge clk);
    rd(OFS_STATUS, 32'h04);
    wr(OFS_WREG, 32'h5A, 1'b0);
    wr(ma(4'h2), 32'h33, 1'b0);
    wr(OFS_INSTR, ins(OP_HALT, 4'h0), 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, sys_clk_en}, 32'h0);
    check({31'h0, halted}, 32'h1);
    // Busy bit masked, though it reads zero while halted
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
    check(q & 32'h17, 32'h12);
    rd(OFS_WDOG, 32'h0);
    rd(OFS_WREG, 32'h5A);
    rd(ma(4'h2), 32'h33);
    rd(ma(4'h9), 32'h11);
    // No instruction runs while halted
    wr(OFS_INSTR, ins(OP_INC_MEM, 4'h2), 1'b1);
    rd(ma(4'h2), 32'h33);
    // Wake keeps both flags as the halt left them
    wr(OFS_WAKE, 32'h1, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, sys_clk_en}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
    check(q & 32'h17, 32'h02);
    wr(OFS_INSTR, ins(OP_INC_MEM, 4'h2), 1'b0);
    rd(ma(4'h2), 32'h34);
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Tests need about 67000 cycles; stop well past that
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    wrap_up();
  end

endmodule
`default_nettype wire
